/* verilog/ppod_port_power.sv */
module ppod_port_power
    import ppod_pkg::*;
#(
    parameter int unsigned N_PORTS     = 6,
    parameter int unsigned TICK_CYCLES = PPOD_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rst_n,
    // Register port
    input  wire logic [15:0]        i_reg_addr,
    input  wire logic               i_reg_wr,
    input  wire logic               i_reg_rd,
    input  wire logic [7:0]         i_reg_wdata,
    output logic      [7:0]         o_reg_rdata,
    // Port control
    input  wire logic               i_ganged_mode,
    input  wire logic [N_PORTS-1:0] i_port_power_en,
    input  wire logic [N_PORTS-1:0] i_oc_clear,
    // Port power sense pins
    input  wire logic [N_PORTS-1:0] i_port_power_sense_pin,
    output logic      [N_PORTS-1:0] o_port_power_sense_pin,
    output logic      [N_PORTS-1:0] o_port_power_sense_pin_oe,
    output logic      [N_PORTS-1:0] o_pullup_en,
    // Overcurrent status
    output logic      [N_PORTS-1:0] o_overcurrent,
    output logic      [N_PORTS-1:0] o_oc_event
);

    logic       tick;
    logic [7:0] lockout_time;
    logic [3:0] min_width;
    logic [7:0] dbl_window;
    logic [7:0] next_lockout_time;
    logic [3:0] next_min_width;
    logic [7:0] next_dbl_window;
    logic [7:0] next_rdata;
    logic [3:0] min_width_eff;

    logic [N_PORTS-1:0] pwr_on;
    logic [N_PORTS-1:0] det;
    logic [N_PORTS-1:0] next_overcurrent;
    logic [N_PORTS-1:0] next_pin_oe;

    ppod_ms_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .o_tick  (tick)
    );

    // Codes above the documented range behave as the largest width.
    assign min_width_eff = (min_width > PPOD_MIN_WIDTH_MAX) ?
                           PPOD_MIN_WIDTH_MAX : min_width;

    always_comb begin
        next_lockout_time = lockout_time;
        next_min_width    = min_width;
        next_dbl_window   = dbl_window;
        next_rdata        = 8'h00;
        if (i_reg_wr) begin
            case (i_reg_addr)
                PPOD_ADDR_LOCKOUT: begin
                    next_lockout_time = i_reg_wdata;
                end
                PPOD_ADDR_MIN_WIDTH: begin
                    next_min_width =
                        i_reg_wdata[PPOD_MIN_WIDTH_MSB:0];
                end
                PPOD_ADDR_DBL_WIN: begin
                    next_dbl_window = i_reg_wdata;
                end
                default: begin
                end
            endcase
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                PPOD_ADDR_LOCKOUT:   next_rdata = lockout_time;
                PPOD_ADDR_MIN_WIDTH: next_rdata = {4'h0, min_width};
                PPOD_ADDR_DBL_WIN:   next_rdata = dbl_window;
                default:             next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lockout_time <= PPOD_RST_LOCKOUT;
            min_width    <= PPOD_RST_MIN_WIDTH;
            dbl_window   <= PPOD_RST_DBL_WIN;
            o_reg_rdata  <= 8'h00;
        end else begin
            lockout_time <= next_lockout_time;
            min_width    <= next_min_width;
            dbl_window   <= next_dbl_window;
            o_reg_rdata  <= next_rdata;
        end
    end

    // In ganged mode port 0's pin is the shared pin and its power request
    // steers every port; the other pins mirror it.
    always_comb begin
        for (int i = 0; i < N_PORTS; i++) begin
            pwr_on[i] = i_ganged_mode ? i_port_power_en[0]
                                      : i_port_power_en[i];
        end
    end

    generate
        for (genvar g = 0; g < N_PORTS; g++) begin : g_port
            ppod_state_t state;
            ppod_state_t next_state;
            logic [7:0]  lock_cnt;
            logic [7:0]  next_lock_cnt;
            logic [3:0]  low_ms;
            logic [3:0]  next_low_ms;
            logic [7:0]  win_cnt;
            logic [7:0]  next_win_cnt;
            logic        armed;
            logic        next_armed;
            logic        prev_low;
            logic        next_prev_low;
            logic        det_r;
            logic        next_det;
            logic        pin_low;
            logic        single_hit;
            logic        double_hit;
            logic        fall;

            always_comb begin
                next_state    = state;
                next_lock_cnt = lock_cnt;
                next_low_ms   = low_ms;
                next_win_cnt  = win_cnt;
                next_armed    = armed;
                next_prev_low = prev_low;
                next_det      = 1'b0;
                pin_low       = ~i_port_power_sense_pin[g];
                single_hit    = 1'b0;
                double_hit    = 1'b0;
                fall          = 1'b0;
                case (state)
                    PPOD_OFF: begin
                        if (pwr_on[g]) begin
                            next_state    = PPOD_LOCKOUT;
                            next_lock_cnt = lockout_time;
                        end
                    end
                    PPOD_LOCKOUT: begin
                        // The pin is not looked at here, so a slow ramp
                        // cannot be mistaken for a fault.
                        if (!pwr_on[g]) begin
                            next_state = PPOD_OFF;
                        end else if (lock_cnt == 8'h00) begin
                            next_state    = PPOD_MONITOR;
                            next_low_ms   = 4'h0;
                            next_win_cnt  = 8'h00;
                            next_armed    = 1'b0;
                            next_prev_low = 1'b0;
                        end else if (tick) begin
                            next_lock_cnt = lock_cnt - 8'h01;
                        end
                    end
                    PPOD_MONITOR: begin
                        if (!pwr_on[g]) begin
                            next_state = PPOD_OFF;
                        end else begin
                            next_prev_low = pin_low;
                            if (!pin_low) begin
                                next_low_ms = 4'h0;
                            end else if (tick && low_ms != 4'hF) begin
                                next_low_ms = low_ms + 4'h1;
                            end
                            single_hit = pin_low
                                && (low_ms >= min_width_eff);
                            fall       = pin_low && !prev_low;
                            double_hit = fall && armed;
                            if (armed && tick) begin
                                next_win_cnt = win_cnt - 8'h01;
                                if (win_cnt <= 8'h01) begin
                                    next_armed = 1'b0;
                                end
                            end
                            if (fall && !armed) begin
                                next_armed   = 1'b1;
                                next_win_cnt = dbl_window;
                            end
                            if (single_hit || double_hit) begin
                                next_det    = 1'b1;
                                next_low_ms = 4'h0;
                                next_armed  = 1'b0;
                            end
                        end
                    end
                    default: begin
                        next_state = PPOD_OFF;
                    end
                endcase
            end

            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    state    <= PPOD_OFF;
                    lock_cnt <= 8'h00;
                    low_ms   <= 4'h0;
                    win_cnt  <= 8'h00;
                    armed    <= 1'b0;
                    prev_low <= 1'b0;
                    det_r    <= 1'b0;
                end else begin
                    state    <= next_state;
                    lock_cnt <= next_lock_cnt;
                    low_ms   <= next_low_ms;
                    win_cnt  <= next_win_cnt;
                    armed    <= next_armed;
                    prev_low <= next_prev_low;
                    det_r    <= next_det;
                end
            end

            assign det[g] = det_r;
        end
    endgenerate

    always_comb begin
        for (int i = 0; i < N_PORTS; i++) begin
            // A new detection wins over a clear in the same cycle.
            next_overcurrent[i] = (o_overcurrent[i] & ~i_oc_clear[i])
                | (i_ganged_mode ? det[0] : det[i]);
            next_pin_oe[i]      = ~pwr_on[i];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_overcurrent             <= '0;
            o_oc_event                <= '0;
            o_port_power_sense_pin_oe <= '1;
            o_pullup_en               <= '0;
            o_port_power_sense_pin    <= '0;
        end else begin
            o_overcurrent             <= next_overcurrent;
            o_oc_event                <= next_overcurrent & ~o_overcurrent;
            o_port_power_sense_pin_oe <= next_pin_oe;
            o_pullup_en               <= ~next_pin_oe;
            o_port_power_sense_pin    <= '0;
        end
    end

endmodule

/* verilog/ppod_pkg.sv */
// Overview of operation
// - Sample the sense pin while port enabled.
// - Flag overcurrent on low lasting minimum width.
// - Flag overcurrent on two lows within window.
// - Ignore the pin during power-on lockout.
// - Minimum width field 3:0, 0-5 ms, default 5.
// - Double-pulse window 8 bits in ms, default 14h.
// - Lockout 8 bits in ms, default 0Ah.
// - Drive the pin low while power is off.
// - Power on: release driver, enable pull-up.
// - Any low while powered means overcurrent; code flags only lows past lockout meeting min width or double-pulse rule.
// - Ganged mode: one overcurrent flags every port.
// - Individual per-port mode is the reset default; code takes the mode from the i_ganged_mode input, with no reset value.
package ppod_pkg;

    localparam int unsigned PPOD_CLK_PERIOD_NS  = 20;
    localparam int unsigned PPOD_TICK_PERIOD_US = 1000;
    localparam int unsigned PPOD_TICK_CYCLES    =
        (PPOD_TICK_PERIOD_US * 1000) / PPOD_CLK_PERIOD_NS;

    localparam int unsigned PPOD_ADDR_W = 16;

    localparam logic [15:0] PPOD_ADDR_LOCKOUT   = 16'h30E1;
    localparam logic [15:0] PPOD_ADDR_MIN_WIDTH = 16'h30EA;
    localparam logic [15:0] PPOD_ADDR_DBL_WIN   = 16'h30EB;

    localparam logic [7:0] PPOD_RST_LOCKOUT   = 8'h0A;
    localparam logic [3:0] PPOD_RST_MIN_WIDTH = 4'h5;
    localparam logic [7:0] PPOD_RST_DBL_WIN   = 8'h14;

    localparam int unsigned PPOD_MIN_WIDTH_MSB = 3;
    localparam logic [3:0]  PPOD_MIN_WIDTH_MAX = 4'h5;

    typedef enum logic [1:0] {
        PPOD_OFF     = 2'b00,
        PPOD_LOCKOUT = 2'b01,
        PPOD_MONITOR = 2'b11
    } ppod_state_t;

endpackage

/* verilog/ppod_ms_tick.sv */
module ppod_ms_tick
    import ppod_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = PPOD_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // Tick
    output logic      o_tick
);

    localparam int unsigned CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          next_tick;

    always_comb begin
        next_tick = (cnt == LAST);
        next_cnt  = next_tick ? '0 : cnt + CW'(1);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt    <= '0;
            o_tick <= 1'b0;
        end else begin
            cnt    <= next_cnt;
            o_tick <= next_tick;
        end
    end

endmodule

/* sim/ppod_props.sv */
module ppod_props
    import ppod_pkg::*;
#(
    parameter int unsigned N_PORTS     = 6,
    parameter int unsigned TICK_CYCLES = PPOD_TICK_CYCLES
) (
    // Clock and reset
    input wire logic               i_clk,
    input wire logic               i_rst_n,
    // Register port and port pins
    input wire logic [15:0]        i_reg_addr,
    input wire logic               i_reg_wr,
    input wire logic               i_reg_rd,
    input wire logic [7:0]         i_reg_wdata,
    input wire logic [7:0]         o_reg_rdata,
    input wire logic               i_ganged_mode,
    input wire logic [N_PORTS-1:0] i_port_power_en,
    input wire logic [N_PORTS-1:0] i_oc_clear,
    input wire logic [N_PORTS-1:0] i_port_power_sense_pin,
    input wire logic [N_PORTS-1:0] o_port_power_sense_pin,
    input wire logic [N_PORTS-1:0] o_port_power_sense_pin_oe,
    input wire logic [N_PORTS-1:0] o_pullup_en,
    input wire logic [N_PORTS-1:0] o_overcurrent,
    input wire logic [N_PORTS-1:0] o_oc_event
);
    timeunit 1ns;
    timeprecision 1ns;
    int on_cnt;
    // Port 1 powered time; a lockout of 2 or more is never shorter than one tick.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) on_cnt <= 0;
        else on_cnt <= i_port_power_en[1] ? on_cnt + 1 : 0;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // In ganged mode the power request of port 0 steers every pin.
    property p_off;
        1 |=> o_port_power_sense_pin_oe == ~($past(i_ganged_mode) ?
            {N_PORTS{$past(i_port_power_en[0])}} : $past(i_port_power_en));
    endproperty
    a_off: assert property (p_off) else $error("drive wrong");
    property p_pull; o_pullup_en == ~o_port_power_sense_pin_oe; endproperty
    a_pull: assert property (p_pull) else $error("pullup wrong");
    property p_low; o_port_power_sense_pin == '0; endproperty
    a_low: assert property (p_low) else $error("pin not low");
    property p_lock;
        $rose(o_overcurrent[1]) && !i_ganged_mode |-> on_cnt > TICK_CYCLES;
    endproperty
    a_lock: assert property (p_lock) else $error("early");
    property p_evt; o_oc_event == (o_overcurrent & ~$past(o_overcurrent));
    endproperty
    a_evt: assert property (p_evt) else $error("event wrong");
    property p_hold;
        1 |=> (o_overcurrent | ~$past(o_overcurrent) | $past(i_oc_clear)) == '1;
    endproperty
    a_hold: assert property (p_hold) else $error("flag lost");
    property p_gang;
        i_ganged_mode && $rose(o_overcurrent[0]) |-> &o_overcurrent;
    endproperty
    a_gang: assert property (p_gang) else $error("gang wrong");
    property p_rsv;
        i_reg_rd && i_reg_addr == PPOD_ADDR_MIN_WIDTH
            |=> o_reg_rdata[7:4] == 4'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved set");
    c_det: cover property (o_oc_event[1]);
    c_gang: cover property (i_ganged_mode && o_oc_event[0]);
    c_read: cover property (i_reg_rd ##1 o_reg_rdata != 8'h00);
endmodule

bind ppod_port_power ppod_props #(
    .N_PORTS(N_PORTS), .TICK_CYCLES(TICK_CYCLES)
) u_ppod_props (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_ganged_mode(i_ganged_mode),
    .i_port_power_en(i_port_power_en), .i_oc_clear(i_oc_clear),
    .i_port_power_sense_pin(i_port_power_sense_pin),
    .o_port_power_sense_pin(o_port_power_sense_pin),
    .o_port_power_sense_pin_oe(o_port_power_sense_pin_oe),
    .o_pullup_en(o_pullup_en), .o_overcurrent(o_overcurrent),
    .o_oc_event(o_oc_event));

/* sim/ppod_switch_model.sv */
module ppod_switch_model #(
    parameter int unsigned N_PORTS = 6
) (
    // Pattern source and device side of the pins
    input  wire logic               i_clk,
    input  wire logic [N_PORTS-1:0] i_drive_oe,
    input  wire logic [N_PORTS-1:0] i_drive_val,
    input  wire logic [N_PORTS-1:0] i_pullup_en,
    // Fault request from the bench and resolved pin level
    input  wire logic [N_PORTS-1:0] i_fault,
    output logic      [N_PORTS-1:0] o_pin
);
    timeunit 1ns; timeprecision 1ns;
    // A tripped switch or opened fuse pulls low at once.
    always_comb begin
        for (int p = 0; p < N_PORTS; p++) begin
            if (i_drive_oe[p]) o_pin[p] = i_drive_val[p];
            else if (i_fault[p]) o_pin[p] = 1'b0;
            else if (i_pullup_en[p]) o_pin[p] = 1'b1;
            else o_pin[p] = i_clk;
        end
    end
endmodule

/* sim/tb_port_power_overcurrent_detect.sv */
module tb_port_power_overcurrent_detect
    import ppod_pkg::*;
;
    timeunit 1ns; timeprecision 1ns;
    logic        i_clk, i_rst_n, wr, rd, gang;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata;
    logic [5:0]  en, clr, flt, pin, pout, oe, pu, oc, exp_oc, ev;
    logic [31:0] rnd;
    logic [7:0]  mreg [3];
    int          bad_count, total_checks, cyc, ev_n;
    ppod_port_power #(.N_PORTS(6), .TICK_CYCLES(10)) u_ppod_port_power (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .i_ganged_mode(gang), .i_port_power_en(en),
        .i_oc_clear(clr), .i_port_power_sense_pin(pin),
        .o_port_power_sense_pin(pout), .o_port_power_sense_pin_oe(oe),
        .o_pullup_en(pu), .o_overcurrent(oc), .o_oc_event(ev));
    ppod_switch_model #(.N_PORTS(6)) u_ppod_switch_model (
        .i_clk(i_clk), .i_drive_oe(oe), .i_drive_val(pout),
        .i_pullup_en(pu), .i_fault(flt), .o_pin(pin));
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        // Event pulses stand one cycle, so they are tallied as they pass.
        ev_n <= ev_n + $countones(ev);
        if (cyc == 8000) begin
            bad_count++;
            stop_test();
        end
    end
    function automatic logic [31:0] xs(logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    function automatic int midx(logic [15:0] a);
        case (a)
            PPOD_ADDR_LOCKOUT:   return 0;
            PPOD_ADDR_MIN_WIDTH: return 1;
            PPOD_ADDR_DBL_WIN:   return 2;
            default:             return 3;
        endcase
    endfunction
    task automatic step(int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic chk(string nm, logic [11:0] seen, logic [11:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wreg(logic [15:0] a, logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        if (midx(a) < 3) begin
            mreg[midx(a)] = (midx(a) == 1) ? (d & 8'h0F) : d;
        end
        step(1);
        wr = 1'b0;
        step(1);
    endtask
    // The third compare shows read data standing a single cycle.
    task automatic rreg(logic [15:0] a, logic [7:0] e);
        addr = a;
        rd = 1'b1;
        step(1);
        rd = 1'b0;
        chk("rdata", rdata, e);
        chk("rdata model", rdata, (midx(a) < 3) ? mreg[midx(a)] : 8'h00);
        step(1);
        chk("rdata idle", rdata, 12'h000);
    endtask
    task automatic low(int p, int n);
        flt[p] = 1'b1;
        step(n);
        flt[p] = 1'b0;
    endtask
    task automatic ocq(logic [5:0] e, int n);
        exp_oc = e;
        chk("overcurrent", oc, exp_oc);
        chk("oc events", 12'(ev_n), 12'(n));
    endtask
    task automatic clear();
        clr = 6'h3F;
        step(1);
        clr = 6'h00;
        step(1);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        {i_rst_n, wr, rd, gang, rnd} = {4'h0, 32'h40};
        {addr, wdata, en, clr, flt, exp_oc} = '0;
        mreg = '{PPOD_RST_LOCKOUT, {4'h0, PPOD_RST_MIN_WIDTH}, PPOD_RST_DBL_WIN};
        step(2);
        i_rst_n = 1'b1;
        rreg(PPOD_ADDR_LOCKOUT, 8'h0A);
        rreg(PPOD_ADDR_MIN_WIDTH, 8'h05);
        rreg(PPOD_ADDR_DBL_WIN, 8'h14);
        wreg(16'h30E2, 8'hFF);
        rreg(16'h30E2, 8'h00);
        rnd = xs(rnd);
        wreg(PPOD_ADDR_MIN_WIDTH, rnd[7:0]);
        rreg(PPOD_ADDR_MIN_WIDTH, {4'h0, rnd[3:0]});
        rnd = xs(rnd);
        wreg(PPOD_ADDR_LOCKOUT, rnd[7:0]);
        rreg(PPOD_ADDR_LOCKOUT, rnd[7:0]);
        chk("pin drive", {oe, pu}, 12'hFC0);
        $display("test registers done");
        wreg(PPOD_ADDR_LOCKOUT, 8'h03);
        wreg(PPOD_ADDR_MIN_WIDTH, 8'h00);
        wreg(PPOD_ADDR_DBL_WIN, 8'h02);
        en = 6'h3F;
        step(1);
        chk("pin drive", {oe, pu}, 12'h03F);
        low(1, 12);
        step(50);
        ocq(6'h00, 0);
        low(1, 1);
        step(3);
        ocq(6'h02, 1);
        clear();
        $display("test lockout done");
        wreg(PPOD_ADDR_MIN_WIDTH, 8'h03);
        low(1, 15);
        step(40);
        ocq(6'h00, 1);
        low(1, 50);
        step(3);
        ocq(6'h02, 2);
        clear();
        $display("test single pulse done");
        wreg(PPOD_ADDR_MIN_WIDTH, 8'h05);
        wreg(PPOD_ADDR_DBL_WIN, 8'h05);
        low(1, 3);
        step(80);
        low(1, 3);
        step(80);
        ocq(6'h00, 2);
        low(1, 3);
        step(17);
        low(1, 3);
        step(3);
        ocq(6'h02, 3);
        clear();
        $display("test double pulse done");
        wreg(PPOD_ADDR_MIN_WIDTH, 8'h00);
        gang = 1'b1;
        low(0, 1);
        step(3);
        ocq(6'h3F, 9);
        gang = 1'b0;
        clear();
        en = 6'h00;
        step(2);
        chk("pin drive", {oe, pu}, 12'hFC0);
        low(1, 5);
        step(3);
        ocq(6'h00, 9);
        $display("test ganged and off done");
        stop_test();
    end
endmodule
